// File: hw/ssmu_top.sv
// Serial unit: APB registers, synchronous and multiprocessor engines
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "ssmu_params.svh"
module ssmu_top #(
  parameter int DIV_W = `SSMU_DIV_W
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe_n,
  input logic serial_clk_i,
  output logic serial_clk_o,
  output logic serial_clk_oe_n,
  input logic port_dir_reg,
  input logic port_data_reg,
  output logic tx_empty_irq,
  output logic tx_end_irq,
  output logic rx_full_irq,
  output logic rx_error_irq,
  output logic irq_req
);
  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (DIV_W < 2 || DIV_W > 16) begin : g_chk
    $error("DIV_W must lie between 2 and 16");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ssmu_pkg::ssmu_ctrl_t ctrl_ff; // Control bits
  ssmu_pkg::ssmu_stat_t stat; // Status readback view
  ssmu_pkg::ssmu_rx_st_t rx_st_ff; // Async receiver state
  logic [DIV_W-1:0] baud_ff; // Divider reload value
  logic [DIV_W-1:0] div_cnt_ff; // Divider counter
  logic [31:0] prdata_ff; // Read data latched in setup
  logic in_s1_ff, in_s2_ff; // Data pin synchroniser
  logic ck_s1_ff, ck_s2_ff, ck_s3_ff; // Clock pin synchroniser and edge stage
  logic sck_ff; // Internal serial clock level
  logic [2:0] sbit_ff; // Synchronous bit position
  logic tx_empty_ff, tx_end_ff, mp_tx_ff; // Transmit flags
  logic [7:0] tx_hold_ff; // Transmit holding register
  logic [10:0] tx_shift_ff; // Transmit shift register
  logic [3:0] tx_cnt_ff, tx_tcnt_ff; // Async bits left, ticks in bit
  logic tx_busy_ff, tx_line_ff; // Transmitter active, line level
  logic rx_full_ff, ovr_ff, ferr_ff, perr_ff, mp_rx_ff; // Receive flags
  logic [7:0] rx_hold_ff, rx_shift_ff; // Receive holding and shift
  logic [3:0] rx_tcnt_ff, rx_idx_ff; // Async ticks and bit index
  logic rx_extra_ff; // Parity or multiprocessor bit
  logic hit, wr_en, rd_en, tick, err_any, rx_on, sync_int;
  logic run, srise, sfall, char_done, has_extra;
  logic tx_wr, tx_can, tx_step, tx_load, tx_end_ev, tx_xbit;
  logic [10:0] tx_frame;
  logic [3:0] tx_len;
  logic rx_stop, rx_done, rx_skip, rx_acc, rx_ferr, rx_perr, rx_xbit;
  logic [7:0] rx_data;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign hit = (paddr == `SSMU_OFS_CTRL) || (paddr == `SSMU_OFS_STAT) || (paddr == `SSMU_OFS_TXD) ||
               (paddr == `SSMU_OFS_RXD) || (paddr == `SSMU_OFS_BAUD);
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_en = psel && penable && !pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_ff;
  assign tx_wr = wr_en && (paddr == `SSMU_OFS_TXD);

  // Status view assembled from the flags
  always_comb begin
    stat.tx_empty_flag = tx_empty_ff;
    stat.rx_full_flag = rx_full_ff;
    stat.overrun_flag = ovr_ff;
    stat.framing_err_flag = ferr_ff;
    stat.parity_err_flag = perr_ff;
    stat.tx_end_flag = tx_end_ff;
    stat.mp_rx_bit = mp_rx_ff;
    stat.mp_tx_bit = mp_tx_ff;
  end

  // Read data captured in the setup cycle, ready in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SSMU_OFS_CTRL: prdata_ff <= {21'h000000, ctrl_ff};
        `SSMU_OFS_STAT: prdata_ff <= {24'h000000, stat};
        `SSMU_OFS_TXD: prdata_ff <= {24'h000000, tx_hold_ff};
        `SSMU_OFS_RXD: prdata_ff <= {24'h000000, rx_hold_ff};
        `SSMU_OFS_BAUD: prdata_ff <= {{(32-DIV_W){1'b0}}, baud_ff};
        default: prdata_ff <= 32'h00000000; // Unmapped reads as zero
      endcase
    end
  end

  // Control register; an accepted ID frame drops skip mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `SSMU_CTRL_RST;
    end else if (wr_en && paddr == `SSMU_OFS_CTRL) begin
      ctrl_ff <= pwdata[`SSMU_CTRL_W-1:0];
    end else if (rx_acc && ctrl_ff.mp_format && rx_xbit) begin
      ctrl_ff.mp_skip_en <= 1'b0;
    end
  end

  // Baud reload and transmit holding register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_ff <= DIV_W'(`SSMU_BAUD_RST);
      tx_hold_ff <= 8'h00;
    end else begin
      if (wr_en && paddr == `SSMU_OFS_BAUD) begin
        baud_ff <= pwdata[DIV_W-1:0];
      end
      if (tx_wr) begin
        tx_hold_ff <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and divider
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1_ff <= 1'b1;
      in_s2_ff <= 1'b1;
      ck_s1_ff <= 1'b1;
      ck_s2_ff <= 1'b1;
      ck_s3_ff <= 1'b1;
    end else begin
      in_s1_ff <= serial_in_pin;
      in_s2_ff <= in_s1_ff;
      ck_s1_ff <= serial_clk_i;
      ck_s2_ff <= ck_s1_ff;
      ck_s3_ff <= ck_s2_ff;
    end
  end

  // Baud tick: one cycle pulse every baud_ff+1 cycles
  assign tick = (div_cnt_ff == '0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= '0;
    end else if (tick) begin
      div_cnt_ff <= baud_ff;
    end else begin
      div_cnt_ff <= div_cnt_ff - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Synchronous serial clock
  // ----------------------------------------------------------------
  assign err_any = ovr_ff || ferr_ff || perr_ff;
  assign rx_on = ctrl_ff.rx_enable && !err_any;
  assign sync_int = ctrl_ff.sync_mode && ctrl_ff.clk_out_sel;
  // Clock runs while transmitting or receiving, and keeps going to finish a started character
  assign run = sync_int && (tx_busy_ff || rx_on || !sck_ff || sbit_ff != 3'h0);
  assign sfall = ctrl_ff.sync_mode && (sync_int ? (tick && run && sck_ff) : (ck_s3_ff && !ck_s2_ff));
  assign srise = ctrl_ff.sync_mode && (sync_int ? (tick && run && !sck_ff) : (ck_s2_ff && !ck_s3_ff));
  assign char_done = srise && (sbit_ff == `SSMU_SYNC_LAST);

  // Internal clock toggles on ticks and rests high between characters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_ff <= 1'b1;
    end else if (!sync_int) begin
      sck_ff <= 1'b1;
    end else if (tick && run) begin
      sck_ff <= !sck_ff;
    end
  end

  // Counts rising edges; eight make one character
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sbit_ff <= 3'h0;
    end else if (!ctrl_ff.sync_mode) begin
      sbit_ff <= 3'h0;
    end else if (srise && (tx_busy_ff || rx_on || sbit_ff != 3'h0)) begin
      sbit_ff <= sbit_ff + 3'h1;
    end
  end

  assign serial_clk_o = sck_ff;
  assign serial_clk_oe_n = !sync_int; // Driven only with internal clock

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  assign has_extra = ctrl_ff.mp_format || ctrl_ff.parity_en;
  // Multiprocessor bit replaces parity
  assign tx_xbit = ctrl_ff.mp_format ? mp_tx_ff : (^tx_hold_ff ^ ctrl_ff.parity_odd);
  assign tx_frame = has_extra ? {1'b1, tx_xbit, tx_hold_ff, 1'b0} : {2'b11, tx_hold_ff, 1'b0};
  assign tx_len = has_extra ? 4'hA : 4'h9;
  assign tx_step = tick && (tx_tcnt_ff == `SSMU_TICK_LAST);
  // Never load in a cycle that writes the holding register
  assign tx_can = ctrl_ff.tx_enable && !tx_empty_ff && !tx_wr && (!ctrl_ff.sync_mode || !err_any);

  always_comb begin
    if (ctrl_ff.sync_mode) begin
      tx_load = tx_can && ((!tx_busy_ff && sbit_ff == 3'h0 && !srise) || (tx_busy_ff && char_done));
      tx_end_ev = tx_busy_ff && char_done && !tx_can;
    end else begin
      tx_load = tx_can && tx_step && (!tx_busy_ff || tx_cnt_ff == 4'h0);
      tx_end_ev = tx_busy_ff && tx_step && tx_cnt_ff == 4'h0 && !tx_can;
    end
  end

  // Tick counter inside an async bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_tcnt_ff <= 4'h0;
    end else if (tick) begin
      tx_tcnt_ff <= tx_tcnt_ff + 4'h1;
    end
  end

  // Shift engine for both modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy_ff <= 1'b0;
      tx_line_ff <= 1'b1;
      tx_shift_ff <= 11'h7FF;
      tx_cnt_ff <= 4'h0;
    end else if (!ctrl_ff.tx_enable) begin
      tx_busy_ff <= 1'b0; // Disable aborts any frame
      tx_line_ff <= 1'b1;
      tx_cnt_ff <= 4'h0;
    end else if (ctrl_ff.sync_mode) begin
      if (tx_load) begin
        tx_busy_ff <= 1'b1;
        tx_shift_ff <= {3'h7, tx_hold_ff};
      end else if (tx_busy_ff && sfall) begin
        tx_line_ff <= tx_shift_ff[0];
        tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
      end else if (tx_end_ev) begin
        tx_busy_ff <= 1'b0; // Line keeps bit 7
      end
    end else if (tx_load) begin
      tx_busy_ff <= 1'b1;
      tx_line_ff <= 1'b0; // Start bit
      tx_shift_ff <= {1'b1, tx_frame[10:1]};
      tx_cnt_ff <= tx_len;
    end else if (tx_busy_ff && tx_step) begin
      if (tx_cnt_ff != 4'h0) begin
        tx_line_ff <= tx_shift_ff[0];
        tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
        tx_cnt_ff <= tx_cnt_ff - 4'h1;
      end else begin
        tx_busy_ff <= 1'b0;
        tx_line_ff <= 1'b1; // mark state
      end
    end
  end

  // Transmit flags; hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_ff <= 1'b1;
      tx_end_ff <= 1'b1;
      mp_tx_ff <= 1'b0;
    end else begin
      if (tx_load || !ctrl_ff.tx_enable) begin
        tx_empty_ff <= 1'b1;
      end else if (tx_wr) begin
        tx_empty_ff <= 1'b0;
      end
      if (tx_end_ev || !ctrl_ff.tx_enable) begin
        tx_end_ff <= 1'b1;
      end else if (tx_load || tx_wr) begin
        tx_end_ff <= 1'b0;
      end
      if (wr_en && paddr == `SSMU_OFS_STAT) begin
        mp_tx_ff <= pwdata[7];
      end
    end
  end

  // Unit drives the pin when enabled, else the port takes it
  assign serial_out_pin = ctrl_ff.tx_enable ? tx_line_ff : port_data_reg;
  assign serial_out_oe_n = ctrl_ff.tx_enable ? 1'b0 : !port_dir_reg;

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  assign rx_stop = (rx_idx_ff == (has_extra ? 4'h9 : `SSMU_DATA_BITS));
  assign rx_xbit = ctrl_ff.sync_mode ? 1'b0 : rx_extra_ff;
  assign rx_data = ctrl_ff.sync_mode ? {in_s2_ff, rx_shift_ff[7:1]} : rx_shift_ff;
  assign rx_ferr = !ctrl_ff.sync_mode && !in_s2_ff;
  assign rx_perr = !ctrl_ff.sync_mode && ctrl_ff.parity_en && !ctrl_ff.mp_format &&
                   ((^{rx_shift_ff, rx_extra_ff}) != ctrl_ff.parity_odd);
  always_comb begin
    if (ctrl_ff.sync_mode) begin
      rx_done = char_done && rx_on;
    end else begin
      rx_done = (rx_st_ff == ssmu_pkg::RX_BITS) && tick && rx_tcnt_ff == `SSMU_TICK_LAST && rx_stop && rx_on;
    end
  end
  // Data frames vanish while skipping
  assign rx_skip = !ctrl_ff.sync_mode && ctrl_ff.mp_format && ctrl_ff.mp_skip_en && !rx_extra_ff;
  assign rx_acc = rx_done && !rx_skip;

  // Shift register and async frame walker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_ff <= ssmu_pkg::RX_IDLE;
      rx_shift_ff <= 8'h00;
      rx_tcnt_ff <= 4'h0;
      rx_idx_ff <= 4'h0;
      rx_extra_ff <= 1'b0;
    end else if (ctrl_ff.sync_mode) begin
      rx_st_ff <= ssmu_pkg::RX_IDLE;
      if (srise && rx_on) begin
        rx_shift_ff <= {in_s2_ff, rx_shift_ff[7:1]};
      end
    end else begin
      case (rx_st_ff)
        ssmu_pkg::RX_IDLE: begin
          rx_tcnt_ff <= 4'h0;
          if (rx_on && !in_s2_ff) begin
            rx_st_ff <= ssmu_pkg::RX_START;
          end
        end
        ssmu_pkg::RX_START: begin
          if (tick) begin
            rx_tcnt_ff <= rx_tcnt_ff + 4'h1;
            if (rx_tcnt_ff == `SSMU_MID_LAST) begin
              rx_tcnt_ff <= 4'h0;
              rx_idx_ff <= 4'h0;
              rx_st_ff <= in_s2_ff ? ssmu_pkg::RX_IDLE : ssmu_pkg::RX_BITS; // Glitch returns to idle
            end
          end
        end
        ssmu_pkg::RX_BITS: begin
          if (tick) begin
            rx_tcnt_ff <= rx_tcnt_ff + 4'h1;
            if (rx_tcnt_ff == `SSMU_TICK_LAST) begin
              rx_idx_ff <= rx_idx_ff + 4'h1;
              if (rx_stop) begin
                rx_st_ff <= ssmu_pkg::RX_IDLE;
              end else if (rx_idx_ff < `SSMU_DATA_BITS) begin
                rx_shift_ff <= {in_s2_ff, rx_shift_ff[7:1]};
              end else begin
                rx_extra_ff <= in_s2_ff;
              end
            end
          end
        end
        default: rx_st_ff <= ssmu_pkg::RX_IDLE;
      endcase
    end
  end

  // Holding register loads only when not full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_hold_ff <= 8'h00;
      mp_rx_ff <= 1'b0;
    end else if (rx_acc && !rx_full_ff) begin
      rx_hold_ff <= rx_data;
      mp_rx_ff <= rx_xbit;
    end
  end

  // Receive flags: hardware set wins, status write of zero clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_full_ff <= 1'b0;
      ovr_ff <= 1'b0;
      ferr_ff <= 1'b0;
      perr_ff <= 1'b0;
    end else begin
      if (rx_acc && !rx_full_ff && !rx_ferr && !rx_perr) begin
        rx_full_ff <= 1'b1;
      end else if (rd_en && paddr == `SSMU_OFS_RXD) begin
        rx_full_ff <= 1'b0;
      end else if (wr_en && paddr == `SSMU_OFS_STAT && !pwdata[1]) begin
        rx_full_ff <= 1'b0;
      end
      if (rx_acc && rx_full_ff) begin
        ovr_ff <= 1'b1;
      end else if (wr_en && paddr == `SSMU_OFS_STAT && !pwdata[2]) begin
        ovr_ff <= 1'b0;
      end
      if (rx_acc && rx_ferr) begin
        ferr_ff <= 1'b1;
      end else if (wr_en && paddr == `SSMU_OFS_STAT && !pwdata[3]) begin
        ferr_ff <= 1'b0;
      end
      if (rx_acc && rx_perr) begin
        perr_ff <= 1'b1;
      end else if (wr_en && paddr == `SSMU_OFS_STAT && !pwdata[4]) begin
        perr_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  assign tx_empty_irq = tx_empty_ff && ctrl_ff.tx_empty_irq_en;
  assign tx_end_irq = tx_end_ff && ctrl_ff.tx_end_irq_en;
  assign rx_full_irq = rx_full_ff && ctrl_ff.rx_irq_en;
  assign rx_error_irq = err_any && ctrl_ff.rx_irq_en;
  assign irq_req = tx_empty_irq || tx_end_irq || rx_full_irq || rx_error_irq;
endmodule

// File: pkg/ssmu_params.svh
// Offsets, widths, reset values and timing counts of the serial unit
`ifndef SSMU_PARAMS_SVH
`define SSMU_PARAMS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SSMU_OFS_CTRL 12'h000
`define SSMU_OFS_STAT 12'h004
`define SSMU_OFS_TXD 12'h008
`define SSMU_OFS_RXD 12'h00C
`define SSMU_OFS_BAUD 12'h010
// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define SSMU_CTRL_W 11
`define SSMU_STAT_W 8
`define SSMU_CTRL_RST 11'h000
`define SSMU_BAUD_RST 16'h0001
`define SSMU_DIV_W 16
// ----------------------------------------------------------------
// Timing counts in baud ticks, clock edges and bits
// ----------------------------------------------------------------
`define SSMU_TICK_LAST 4'hF
`define SSMU_MID_LAST 4'h7
`define SSMU_SYNC_LAST 3'h7
`define SSMU_DATA_BITS 4'h8
`endif

// File: pkg/ssmu_pkg.sv
// Types of the serial unit: control and status layouts, engine states
package ssmu_pkg;
  // Control register layout, bit 0 at the bottom
  typedef struct packed {
    logic parity_odd;
    logic parity_en;
    logic mp_format;
    logic clk_out_sel;
    logic sync_mode;
    logic mp_skip_en;
    logic tx_end_irq_en;
    logic rx_irq_en;
    logic tx_empty_irq_en;
    logic rx_enable;
    logic tx_enable;
  } ssmu_ctrl_t;
  // Status register layout, bit 0 at the bottom
  typedef struct packed {
    logic mp_tx_bit;
    logic mp_rx_bit;
    logic tx_end_flag;
    logic parity_err_flag;
    logic framing_err_flag;
    logic overrun_flag;
    logic rx_full_flag;
    logic tx_empty_flag;
  } ssmu_stat_t;
  // Asynchronous receiver states
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} ssmu_rx_st_t;
endpackage

// File: tb/ssmu_chk.sv
// Port checker of the serial unit
`timescale 1ns/10ps
module ssmu_chk (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic serial_out_pin,
  input logic serial_out_oe_n,
  input logic serial_clk_o,
  input logic serial_clk_oe_n,
  input logic port_data_reg,
  input logic tx_empty_irq,
  input logic tx_end_irq,
  input logic rx_full_irq,
  input logic rx_error_irq,
  input logic irq_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Clock pulses counted within one character
  logic [2:0] rise_ff;
  // APB access phase
  sequence s_acc;
    psel && penable;
  endsequence
  // Count driven serial clock pulses modulo eight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_ff <= 3'h0;
    end else if (!serial_clk_oe_n && $rose(serial_clk_o)) begin
      rise_ff <= rise_ff + 3'h1;
    end
  end
  a_irq_shared: assert property (irq_req == (tx_empty_irq | tx_end_irq | rx_full_irq | rx_error_irq))
    else $error("shared request differs from its causes");
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("access phase not ready");
  a_bad_addr: assert property (s_acc ##0 (paddr > 12'h010) |-> pslverr)
    else $error("unmapped access not refused");
  a_read_upper: assert property (s_acc ##0 !pwrite |-> prdata[31:16] == 16'h0)
    else $error("read data upper half not zero");
  a_tx_bit_hold: assert property (!serial_clk_oe_n && !serial_out_oe_n && serial_clk_o
    && $past(serial_clk_o) && !$past(serial_out_oe_n) |-> $stable(serial_out_pin))
    else $error("transmit bit changed outside falling edge");
  a_eight_pulses: assert property ((!serial_clk_oe_n && serial_clk_o) [*8] |-> rise_ff == 3'h0)
    else $error("clock stopped inside a character");
  a_clk_idle_hi: assert property (serial_clk_oe_n |-> serial_clk_o)
    else $error("serial clock not high when idle");
  a_port_ctrl: assert property (serial_out_oe_n |-> serial_out_pin == port_data_reg)
    else $error("line not under port control");
endmodule

// File: tb/ssmu_peer.sv
// Far-side serial peer: clocked shifter, external clock, loopback
`timescale 1ns/10ps
module ssmu_peer (
  input logic serial_out_pin,
  input logic serial_clk_o,
  input logic ext_mode,
  input logic loop_en,
  input logic [15:0] rx_pair,
  output logic serial_in_pin,
  output logic serial_clk_i
);
  logic [15:0] got; // Captured line bits, newest at top
  logic [3:0] idx; // Position of next bit sent
  logic drv, sck;
  // Clock seen by the peer
  assign sck = ext_mode ? serial_clk_i : serial_clk_o;
  // Loopback joins the line to the receiver
  assign serial_in_pin = loop_en ? serial_out_pin : drv;
  initial begin
    serial_clk_i = 1'b1;
    drv = 1'b1;
    idx = 4'h0;
    got = 16'h0;
  end
  // New bit from each falling edge
  always @(negedge sck) begin
    drv = rx_pair[idx];
  end
  // Line taken on the rising edge
  always @(posedge sck) begin
    got = {serial_out_pin, got[15:1]};
    idx = idx + 4'h1;
  end
  // Eight pulses of 62.5 ns low every 125 ns, then still high
  task automatic burst();
    repeat (8) begin
      #62.5 serial_clk_i = 1'b0;
      #62.5 serial_clk_i = 1'b1;
    end
  endtask
endmodule

// File: tb/ssmu_top_tb.sv
// Testbench of the serial unit
`timescale 1ns/10ps
module ssmu_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_mode, loop_en;
  logic serial_in_pin, serial_out_pin, serial_out_oe_n, serial_clk_i, serial_clk_o, serial_clk_oe_n;
  logic port_dir_reg, port_data_reg, tx_empty_irq, tx_end_irq, rx_full_irq, rx_error_irq, irq_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] rx_pair;
  int failures, num_checks, cyc;
  ssmu_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n),
    .serial_clk_i(serial_clk_i), .serial_clk_o(serial_clk_o), .serial_clk_oe_n(serial_clk_oe_n),
    .port_dir_reg(port_dir_reg), .port_data_reg(port_data_reg), .tx_empty_irq(tx_empty_irq),
    .tx_end_irq(tx_end_irq), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq), .irq_req(irq_req));
  ssmu_peer peer_u (.serial_out_pin(serial_out_pin), .serial_clk_o(serial_clk_o), .ext_mode(ext_mode),
    .loop_en(loop_en), .rx_pair(rx_pair), .serial_in_pin(serial_in_pin), .serial_clk_i(serial_clk_i));
  // Clock and hang limit
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures = failures + 1;
      results();
    end
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data lands in rd
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll status until bit b is set
  task automatic wait_stat(input int b);
    rd = 32'h0;
    while (rd[b] !== 1'b1) apb(1'b0, 12'h004, 32'h0);
  endtask
  // Reset values and early transmit requests
  task automatic t_reset();
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h21);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h14);
    @(negedge pclk);
    chk({29'h0, tx_empty_irq, tx_end_irq, irq_req}, 32'h7);
  endtask
  // Internal clock transmit, chained then ended
  task automatic t_sync_tx();
    apb(1'b1, 12'h010, 32'h3);
    apb(1'b1, 12'h000, 32'hC1);
    apb(1'b1, 12'h008, 32'h3C);
    apb(1'b1, 12'h000, 32'hD5);
    wait_stat(0);
    apb(1'b1, 12'h008, 32'h96);
    wait_stat(5);
    @(negedge pclk);
    chk({16'h0, peer_u.got}, 32'h963C);
    chk({30'h0, serial_out_pin, serial_clk_o}, 32'h3);
    chk({30'h0, tx_end_irq, irq_req}, 32'h3);
  endtask
  // External clock transmit
  task automatic t_ext();
    apb(1'b1, 12'h000, 32'h41);
    apb(1'b1, 12'h008, 32'hE1);
    ext_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    peer_u.burst();
    @(negedge pclk);
    chk({24'h0, peer_u.got[15:8]}, 32'hE1);
    ext_mode <= 1'b0;
  endtask
  // Receive with overrun, then blocked transmit
  task automatic t_sync_rx();
    apb(1'b1, 12'h000, 32'h0);
    peer_u.idx = 4'h0;
    rx_pair <= 16'hA75A;
    apb(1'b1, 12'h000, 32'hCA);
    wait_stat(2);
    @(negedge pclk);
    chk({30'h0, rx_full_irq, rx_error_irq}, 32'h3);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h3F, 32'h27);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h5A);
    apb(1'b1, 12'h000, 32'hC1);
    apb(1'b1, 12'h008, 32'h55);
    repeat (100) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h3F, 32'h04);
    apb(1'b1, 12'h004, 32'h0);
    wait_stat(5);
    chk({24'h0, peer_u.got[15:8]}, 32'h55);
  endtask
  // Multiprocessor loopback with skipping, then break
  task automatic t_mp();
    loop_en <= 1'b1;
    // Mode change only with both directions disabled
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'h323);
    apb(1'b1, 12'h008, 32'h11);
    wait_stat(5);
    chk(rd & 32'h2, 32'h0);
    apb(1'b1, 12'h004, 32'h80);
    apb(1'b1, 12'h008, 32'h22);
    wait_stat(1);
    chk(rd & 32'hDF, 32'hC3);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h22);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h303);
    // Own ID taken as different: skipping is armed again
    apb(1'b1, 12'h000, 32'h323);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h008, 32'h33);
    wait_stat(5);
    chk(rd & 32'h2, 32'h0);
    wait_stat(5);
    chk({31'h0, serial_out_pin}, 32'h1);
    port_data_reg <= 1'b0;
    apb(1'b1, 12'h000, 32'h0);
    @(negedge pclk);
    chk({30'h0, serial_out_pin, serial_out_oe_n}, 32'h0);
  endtask
  // Verdict and end of run
  task automatic results();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, ext_mode, loop_en, presetn} = 6'h0;
    {port_dir_reg, port_data_reg} = 2'h3;
    paddr = 12'h0;
    pwdata = 32'h0;
    rx_pair = 16'hFFFF;
    {failures, num_checks, cyc} = {32'h0, 32'h0, 32'h0};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sync_tx();
    t_ext();
    t_sync_rx();
    t_mp();
    results();
  end
endmodule
bind ssmu_top ssmu_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n), .serial_clk_o(serial_clk_o),
  .serial_clk_oe_n(serial_clk_oe_n), .port_data_reg(port_data_reg), .tx_empty_irq(tx_empty_irq),
  .tx_end_irq(tx_end_irq), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq), .irq_req(irq_req));
